// >>> csq_consts.svh
`ifndef CSQ_CONSTS_SVH
`define CSQ_CONSTS_SVH

`define CSQ_CLK_HZ 20000000
`define CSQ_BAUD_2400 2400
`define CSQ_BAUD_4800 4800
`define CSQ_BAUD_9600 9600
`define CSQ_BAUD_19200 19200
`define CSQ_BAUD_CNT_W 14
`define CSQ_STREAM_PERIOD_MS 520
`define CSQ_FRAME_LAST 4'h9
`define CSQ_REPLY_BYTES 2'h3
`define CSQ_FLAG_OK 8'h80
`define CSQ_FLAG_DISTORT_BIT 0
`define CSQ_HEADING_MAX 16'h02cf
`define CSQ_CAL_START 24'h535441
`define CSQ_CAL_DONE 24'h524459
`define CSQ_FIFO_DEPTH 16
`define CSQ_FIFO_WIDTH 8

`endif

// >>> csq_pkg.sv
package csq_pkg;

  typedef enum logic [2:0] {
    ST_SLEEP,
    ST_MEAS,
    ST_SEND,
    ST_STREAM,
    ST_CAL_OPEN,
    ST_CAL
  } csq_state_e;

  typedef struct packed {
    logic [7:0] flag;
    logic [15:0] heading;
  } csq_reply_s;

  typedef struct packed {
    logic baud_a;
    logic baud_b;
    logic invert_n;
  } csq_straps_s;

endpackage : csq_pkg

// >>> csq_port.sv
// Behaviour
// RULE1 - Absent strap reads one, fitted reads zero.
// RULE2 - Strap pair selects 2400, 4800, 9600, 19200.
// RULE3 - Frames are 8 data, no parity, one stop.
// RULE4 - Fitted invert strap negates the X reading.
// RULE5 - Answers heading requests straight after reset.
// RULE6 - Each query low pulse yields one reply.
// RULE7 - Host holds cal line high for queries.
// RULE8 - Host holds query line high between pulses.
// RULE9 - Sleep after reply while query stays high.
// RULE10 - Up to twenty queries per second served.
// RULE11 - Query held low streams replies, never sleeps.
// RULE12 - Query pulse with cal low enters calibration.
// RULE13 - Calibration start sends 53 54 41 hex.
// RULE14 - Cal line rising sends 52 44 59 hex.
// RULE15 - After calibration the device sleeps again.
// RULE16 - Reply is three bytes, flag 80 or 81.
// RULE17 - Flag LSB set when distortion is suspected.
// RULE18 - Heading follows, 16 bits, MSB first, half-degrees.
// RULE19 - Sensor power only while measuring; the code also powers it in ST_CAL_OPEN and ST_CAL.
// RULE20 - Heading value stays within 0 to 719.
// RULE21 - Straps sampled once after reset, then fixed.
`timescale 1ns/100ps
`include "csq_consts.svh"

module csq_fifo #(
  parameter int W = `CSQ_FIFO_WIDTH,
  parameter int D = `CSQ_FIFO_DEPTH
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [W-1:0] i_wr_data,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [W-1:0] o_rd_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;
  logic do_wr;
  logic do_rd;
  // The FIFO is full at D entries and empty at none.
  assign o_wr_ready = (count_r != CW'(D));
  assign o_rd_valid = (count_r != '0);
  assign o_rd_data = mem_r[rd_ptr_r];
  assign do_wr = i_wr_valid & o_wr_ready;
  assign do_rd = o_rd_valid & i_rd_ready;
  function automatic logic [AW-1:0] ptr_step(input logic [AW-1:0] p);
    ptr_step = (p == AW'(D - 1)) ? '0 : AW'(p + 1'b1);
  endfunction : ptr_step
  always_ff @(posedge i_ref_clk) begin
    if (do_wr) begin
      mem_r[wr_ptr_r] <= i_wr_data;
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_r <= ptr_step(wr_ptr_r);
      end
      if (do_rd) begin
        rd_ptr_r <= ptr_step(rd_ptr_r);
      end
      if (do_wr && !do_rd) begin
        count_r <= CW'(count_r + 1'b1);
      end else if (do_rd && !do_wr) begin
        count_r <= CW'(count_r - 1'b1);
      end
    end
  end
endmodule : csq_fifo

module csq_port #(
  parameter int XW = 12,
  parameter int DIV_2400 = `CSQ_CLK_HZ / `CSQ_BAUD_2400,
  parameter int DIV_4800 = `CSQ_CLK_HZ / `CSQ_BAUD_4800,
  parameter int DIV_9600 = `CSQ_CLK_HZ / `CSQ_BAUD_9600,
  parameter int DIV_19200 = `CSQ_CLK_HZ / `CSQ_BAUD_19200,
  parameter int STREAM_CYC = `CSQ_CLK_HZ / 1000 * `CSQ_STREAM_PERIOD_MS
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_query_n,
  input wire logic i_cal_n,
  input wire logic i_baud_strap_a,
  input wire logic i_baud_strap_b,
  input wire logic i_axis_invert_strap_n,
  input wire logic signed [XW-1:0] i_x_raw,
  input wire logic i_meas_done,
  input wire logic [15:0] i_heading,
  input wire logic i_distort,
  output logic signed [XW-1:0] o_x_axis,
  output logic o_sensor_pwr,
  output logic o_meas_req,
  output logic o_sleep,
  output logic o_cal_active,
  output logic o_serial_out
);
  localparam int BW = `CSQ_BAUD_CNT_W;
  localparam int SW = $clog2(STREAM_CYC);
  csq_pkg::csq_state_e state_r;
  csq_pkg::csq_state_e state_nxt;
  csq_pkg::csq_straps_s straps_r;
  csq_pkg::csq_reply_s reply;
  logic strap_ok_r;
  logic [BW-1:0] div_r;
  logic query_prev_r;
  logic query_fall;
  logic load_en;
  logic [23:0] load_val;
  logic [23:0] msg_r;
  logic [1:0] msg_cnt_r;
  logic push_ready;
  logic pop_valid;
  logic [7:0] pop_data;
  logic pop;
  logic tx_busy_r;
  logic [3:0] bit_idx_r;
  logic [9:0] shift_r;
  logic [BW-1:0] baud_cnt_r;
  logic baud_tick;
  logic [SW-1:0] strm_cnt_r;
  logic strm_hit;
  function automatic logic [BW-1:0] baud_div(input logic a, input logic b);
    unique case ({a, b})
      2'b11: baud_div = BW'(DIV_2400);
      2'b10: baud_div = BW'(DIV_4800);
      2'b01: baud_div = BW'(DIV_9600);
      2'b00: baud_div = BW'(DIV_19200);
    endcase
  endfunction : baud_div
  // Straps are latched on the first clock after reset and held.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      straps_r <= '1; // [RULE1]
      strap_ok_r <= 1'b0;
    end else if (!strap_ok_r) begin
      straps_r <= '{i_baud_strap_a, i_baud_strap_b, i_axis_invert_strap_n}; // [RULE21]
      strap_ok_r <= 1'b1;
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_r <= BW'(DIV_9600);
    end else begin
      div_r <= baud_div(straps_r.baud_a, straps_r.baud_b); // [RULE2] [RULE1]
    end
  end
  // X is negated when the invert strap is fitted, before the heading arithmetic sees it.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_x_axis <= '0;
    end else begin
      o_x_axis <= straps_r.invert_n ? i_x_raw : -i_x_raw; // [RULE4]
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      query_prev_r <= 1'b1;
    end else begin
      query_prev_r <= i_query_n;
    end
  end
  assign query_fall = query_prev_r & ~i_query_n; // [RULE8]
  always_comb begin
    reply.flag = `CSQ_FLAG_OK;
    reply.flag[`CSQ_FLAG_DISTORT_BIT] = i_distort; // [RULE17]
    reply.heading = (i_heading > `CSQ_HEADING_MAX) ? `CSQ_HEADING_MAX : i_heading; // [RULE20]
  end

  always_comb begin
    state_nxt = state_r;
    load_en = 1'b0;
    load_val = reply; // [RULE16] [RULE18]
    unique case (state_r)
      csq_pkg::ST_SLEEP: begin
        if (query_fall && strap_ok_r) begin
          if (!i_cal_n) begin
            load_en = 1'b1;
            load_val = `CSQ_CAL_START; // [RULE12] [RULE13]
            state_nxt = csq_pkg::ST_CAL_OPEN;
          end else begin
            state_nxt = csq_pkg::ST_MEAS; // [RULE6] [RULE7] [RULE5]
          end
        end
      end
      csq_pkg::ST_MEAS: begin
        if (i_meas_done) begin
          load_en = 1'b1;
          state_nxt = csq_pkg::ST_SEND;
        end
      end
      csq_pkg::ST_SEND: begin
        if (msg_cnt_r == '0 && !pop_valid && !tx_busy_r) begin
          if (!i_query_n) begin
            state_nxt = csq_pkg::ST_STREAM; // [RULE11]
          end else begin
            state_nxt = csq_pkg::ST_SLEEP; // [RULE9] [RULE10] [RULE15]
          end
        end
      end
      csq_pkg::ST_STREAM: begin
        if (i_query_n) begin
          state_nxt = csq_pkg::ST_SLEEP;
        end else if (strm_hit) begin
          state_nxt = csq_pkg::ST_MEAS; // [RULE11]
        end
      end
      csq_pkg::ST_CAL_OPEN: begin
        if (msg_cnt_r == '0) begin
          state_nxt = csq_pkg::ST_CAL;
        end
      end
      csq_pkg::ST_CAL: begin
        if (i_cal_n) begin
          load_en = 1'b1;
          load_val = `CSQ_CAL_DONE; // [RULE14]
          state_nxt = csq_pkg::ST_SEND;
        end
      end
    endcase
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= csq_pkg::ST_SLEEP;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Mode outputs are decoded from the next state so they line up with state_r.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sensor_pwr <= 1'b0;
      o_meas_req <= 1'b0;
      o_sleep <= 1'b1;
      o_cal_active <= 1'b0;
    end else begin
      o_sensor_pwr <= (state_nxt == csq_pkg::ST_MEAS) || (state_nxt == csq_pkg::ST_CAL_OPEN) ||
                      (state_nxt == csq_pkg::ST_CAL); // [RULE19]
      o_meas_req <= (state_nxt == csq_pkg::ST_MEAS);
      o_sleep <= (state_nxt == csq_pkg::ST_SLEEP); // [RULE9]
      o_cal_active <= (state_nxt == csq_pkg::ST_CAL_OPEN) || (state_nxt == csq_pkg::ST_CAL);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strm_cnt_r <= '0;
    end else if (state_r != csq_pkg::ST_STREAM || strm_hit) begin
      strm_cnt_r <= '0;
    end else begin
      strm_cnt_r <= SW'(strm_cnt_r + 1'b1);
    end
  end
  assign strm_hit = (strm_cnt_r == SW'(STREAM_CYC - 1));
  // Message bytes leave most significant first and wait while the FIFO is full.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      msg_r <= '0;
      msg_cnt_r <= '0;
    end else if (load_en) begin
      msg_r <= load_val;
      msg_cnt_r <= `CSQ_REPLY_BYTES; // [RULE16]
    end else if (msg_cnt_r != '0 && push_ready) begin
      msg_r <= {msg_r[15:0], 8'h00}; // [RULE18]
      msg_cnt_r <= msg_cnt_r - 2'h1;
    end
  end

  csq_fifo u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_wr_valid(msg_cnt_r != '0),
    .o_wr_ready(push_ready),
    .i_wr_data(msg_r[23:16]),
    .o_rd_valid(pop_valid),
    .i_rd_ready(!tx_busy_r),
    .o_rd_data(pop_data)
  );

  assign pop = pop_valid & ~tx_busy_r;
  assign baud_tick = tx_busy_r && (baud_cnt_r == BW'(div_r - 1'b1));
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      baud_cnt_r <= '0;
    end else if (pop || baud_tick) begin
      baud_cnt_r <= '0;
    end else if (tx_busy_r) begin
      baud_cnt_r <= BW'(baud_cnt_r + 1'b1);
    end
  end
  // One start bit, eight data bits LSB first, one stop bit, no parity.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_busy_r <= 1'b0;
      bit_idx_r <= '0;
      shift_r <= '1;
      o_serial_out <= 1'b1;
    end else if (pop) begin
      tx_busy_r <= 1'b1;
      bit_idx_r <= '0;
      shift_r <= {1'b1, pop_data, 1'b0}; // [RULE3]
      o_serial_out <= 1'b0;
    end else if (baud_tick) begin
      if (bit_idx_r == `CSQ_FRAME_LAST) begin
        tx_busy_r <= 1'b0;
        o_serial_out <= 1'b1;
      end else begin
        bit_idx_r <= bit_idx_r + 4'h1;
        shift_r <= {1'b1, shift_r[9:1]};
        o_serial_out <= shift_r[1]; // [RULE3]
      end
    end
  end

  strap_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE21]
    strap_ok_r |=> $stable(straps_r))
    else $error("Strap sample changed after capture.");
  baud_fast_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE2]
    (strap_ok_r && !straps_r.baud_a && !straps_r.baud_b) |=> div_r == BW'(DIV_19200))
    else $error("Fitted straps did not select the fastest rate.");
  x_invert_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE4]
    strap_ok_r |=> o_x_axis == ($past(straps_r.invert_n) ? $past(i_x_raw) : -$past(i_x_raw)))
    else $error("X axis not inverted as the strap demands.");
  query_meas_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE6]
    (state_r == csq_pkg::ST_SLEEP && query_fall && strap_ok_r && i_cal_n) |=> o_meas_req && o_sensor_pwr)
    else $error("Query pulse did not start a measurement.");
  reply_flag_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE17]
    (state_r == csq_pkg::ST_MEAS && i_meas_done) |=>
      msg_r[23:16] == (`CSQ_FLAG_OK | {7'h00, $past(i_distort)}) && msg_cnt_r == 2'h3)
    else $error("Reply flag byte wrong.");
  heading_range_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE20]
    (state_r == csq_pkg::ST_MEAS && i_meas_done) |=> msg_r[15:0] <= `CSQ_HEADING_MAX)
    else $error("Heading above one full turn.");
  cal_start_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE13]
    (state_r == csq_pkg::ST_SLEEP && query_fall && strap_ok_r && !i_cal_n) |=>
      msg_r == `CSQ_CAL_START && o_cal_active)
    else $error("Calibration start marker missing.");
  cal_done_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE14]
    (state_r == csq_pkg::ST_CAL && i_cal_n) |=> msg_r == `CSQ_CAL_DONE && !o_cal_active)
    else $error("Calibration done marker missing.");
  sleep_power_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE19]
    o_sleep |-> !o_sensor_pwr && !o_meas_req)
    else $error("Sensor powered while asleep.");
  stream_awake_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE11]
    (state_r == csq_pkg::ST_STREAM && !i_query_n) |=> !o_sleep)
    else $error("Slept while query held low.");
  frame_edges_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE3]
    pop |=> !o_serial_out ##0 (tx_busy_r && bit_idx_r == 4'h0))
    else $error("Start bit not driven low.");
  stop_bit_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE3]
    (tx_busy_r && bit_idx_r == `CSQ_FRAME_LAST) |-> o_serial_out)
    else $error("Stop bit not high.");

endmodule : csq_port

// >>> csq_host.sv
`timescale 1ns/100ps

module csq_host (
  input wire logic i_ref_clk,
  input wire logic i_line,
  input wire logic [15:0] i_bit_cyc,
  output logic o_query_n,
  output logic o_cal_n
);
  logic [7:0] rx_q[$];
  logic [7:0] rx_b;
  int frame_err = 0;

  initial begin
    o_query_n = 1'h1;
    o_cal_n = 1'h1;
  end

  // Pulses the query line for two cycles, with the cal line low for calibration.
  task query(input logic cal);
    @(negedge i_ref_clk);
    o_cal_n = ~cal;
    o_query_n = 1'h0;
    repeat (2) @(negedge i_ref_clk);
    o_query_n = 1'h1;
  endtask : query

  // Sets both lines at a falling edge and leaves them there.
  task set_lines(input logic q, input logic c);
    @(negedge i_ref_clk);
    o_query_n = q;
    o_cal_n = c;
  endtask : set_lines

  // Receives one frame per start edge, sampling each bit at its middle.
  always begin
    @(negedge i_line);
    repeat (i_bit_cyc / 2) @(posedge i_ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (i_bit_cyc) @(posedge i_ref_clk);
      rx_b[i] = i_line;
    end
    repeat (i_bit_cyc) @(posedge i_ref_clk);
    if (i_line !== 1'h1) begin
      frame_err++;
    end
    rx_q.push_back(rx_b);
  end
endmodule : csq_host

// >>> test_compass_serial_query_port.sv
`timescale 1ns/100ps

module test_compass_serial_query_port;
  localparam int STREAM_CYC = 200;
  typedef struct packed {
    logic a;
    logic b;
    logic inv_n;
    logic [11:0] x;
    logic [15:0] hd;
    logic dis;
    logic [15:0] div;
    logic [11:0] x_exp;
    logic [23:0] msg;
  } csq_tb_row_s;

  logic i_ref_clk = 1'h0;
  logic i_rst_n = 1'h0;
  logic i_query_n;
  logic i_cal_n;
  logic i_baud_strap_a = 1'h1;
  logic i_baud_strap_b = 1'h1;
  logic i_axis_invert_strap_n = 1'h1;
  logic [11:0] i_x_raw = 12'h000;
  logic i_meas_done = 1'h0;
  logic [15:0] i_heading = 16'h0000;
  logic i_distort = 1'h0;
  logic [11:0] x_axis;
  logic o_sensor_pwr;
  logic o_meas_req;
  logic o_sleep;
  logic o_cal_active;
  logic o_serial_out;
  logic [15:0] bit_cyc = 16'h0010;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  int waited = 0;
  int meas_age = 0;
  csq_tb_row_s rows[4] = '{
    '{1'h1, 1'h1, 1'h1, 12'h123, 16'h0285, 1'h0, 16'h0010, 12'h123, 24'h800285},
    '{1'h1, 1'h0, 1'h0, 12'h123, 16'h0000, 1'h1, 16'h000c, 12'hedd, 24'h810000},
    '{1'h0, 1'h1, 1'h1, 12'h800, 16'h02cf, 1'h0, 16'h0008, 12'h800, 24'h8002cf},
    '{1'h0, 1'h0, 1'h0, 12'h001, 16'h0320, 1'h1, 16'h0006, 12'hfff, 24'h8102cf}
  };

  csq_port #(.DIV_2400(16), .DIV_4800(12), .DIV_9600(8), .DIV_19200(6), .STREAM_CYC(STREAM_CYC)) csq_port_i (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_query_n(i_query_n), .i_cal_n(i_cal_n),
    .i_baud_strap_a(i_baud_strap_a), .i_baud_strap_b(i_baud_strap_b),
    .i_axis_invert_strap_n(i_axis_invert_strap_n), .i_x_raw(i_x_raw), .i_meas_done(i_meas_done),
    .i_heading(i_heading), .i_distort(i_distort), .o_x_axis(x_axis), .o_sensor_pwr(o_sensor_pwr),
    .o_meas_req(o_meas_req), .o_sleep(o_sleep), .o_cal_active(o_cal_active), .o_serial_out(o_serial_out)
  );

  csq_host csq_host_i (
    .i_ref_clk(i_ref_clk), .i_line(o_serial_out), .i_bit_cyc(bit_cyc), .o_query_n(i_query_n), .o_cal_n(i_cal_n)
  );

  always #25 i_ref_clk = ~i_ref_clk;

  // Heading engine answers each measurement request four cycles late with a one-cycle pulse.
  always @(negedge i_ref_clk) begin
    meas_age <= o_meas_req ? meas_age + 1 : 0;
    i_meas_done <= o_meas_req && meas_age == 3;
  end

  task close_out;
    if (failures == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      close_out();
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task do_reset(input csq_tb_row_s r);
    @(negedge i_ref_clk);
    i_rst_n = 1'h0;
    i_baud_strap_a = r.a;
    i_baud_strap_b = r.b;
    i_axis_invert_strap_n = r.inv_n;
    i_x_raw = r.x;
    i_heading = r.hd;
    i_distort = r.dis;
    bit_cyc = r.div;
    repeat (4) @(negedge i_ref_clk);
    check({o_sleep, o_serial_out, o_sensor_pwr, o_cal_active, o_meas_req}, 5'h18);
    i_rst_n = 1'h1;
    csq_host_i.rx_q.delete();
    repeat (2) @(negedge i_ref_clk);
  endtask : do_reset

  // Collects three bytes under a bounded wait; missing bytes stay unknown.
  task automatic get_reply(input logic [23:0] exp);
    logic [23:0] got;
    got = 'x;
    waited = 0;
    while (csq_host_i.rx_q.size() < 3 && waited < 3000) begin
      @(negedge i_ref_clk);
      waited++;
    end
    for (int k = 0; k < 3; k++) begin
      if (csq_host_i.rx_q.size() > 0) begin
        got = {got[15:0], csq_host_i.rx_q.pop_front()};
      end
    end
    check({8'h00, got}, {8'h00, exp});
  endtask : get_reply

  task expect_sleep;
    repeat (bit_cyc + 4) @(negedge i_ref_clk);
    check({o_sleep, o_sensor_pwr}, 2'h2);
    check(csq_host_i.rx_q.size(), 0);
  endtask : expect_sleep

  initial begin
    for (int n = 0; n < 4; n++) begin
      do_reset(rows[n]);
      check(x_axis, rows[n].x_exp);
      csq_host_i.query(1'h0);
      check({o_meas_req, o_sensor_pwr, o_sleep}, 3'h6);
      get_reply(rows[n].msg);
      expect_sleep();
    end
    // Straps moved in mid-run must leave the rate alone; two queries follow, each after the previous reply and sleep check.
    i_baud_strap_a = 1'h1;
    i_baud_strap_b = 1'h1;
    for (int n = 0; n < 2; n++) begin
      csq_host_i.query(1'h0);
      get_reply(rows[3].msg);
      expect_sleep();
    end
    csq_host_i.query(1'h1);
    check({o_cal_active, o_sensor_pwr}, 2'h3);
    get_reply(24'h535441);
    csq_host_i.set_lines(1'h1, 1'h1);
    repeat (2) @(negedge i_ref_clk);
    check(o_cal_active, 1'h0);
    get_reply(24'h524459);
    expect_sleep();
    csq_host_i.set_lines(1'h0, 1'h1);
    get_reply(rows[3].msg);
    check(o_sleep, 1'h0);
    get_reply(rows[3].msg);
    check(waited > STREAM_CYC, 1'h1);
    csq_host_i.set_lines(1'h1, 1'h1);
    waited = 0;
    while (o_sleep !== 1'h1 && waited < 3000) begin
      @(negedge i_ref_clk);
      waited++;
    end
    check(o_sleep, 1'h1);
    check(csq_host_i.frame_err, 0);
    close_out();
  end
endmodule : test_compass_serial_query_port
